// *** src/burst_sequencer.sv ***
`timescale 1ns/10ps
module burst_sequencer #(
   parameter int ON_CYC = reader_pkg::BURST_ON_CYC,
   parameter int OFF_CYC = reader_pkg::BURST_OFF_CYC,
   parameter int IDLE_CYC = reader_pkg::IDLE_CYC,
   parameter int BEEP_CYC = reader_pkg::BEEP_CYC,
   parameter int DB_CYC = reader_pkg::DEBOUNCE_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Button and demodulator pins
   input wire logic read_button,
   input wire logic hdx_data,
   input wire logic fdx_data,
   input wire logic rtc_clk,
   // Configuration store
   output logic cfg_read,
   input wire logic cfg_ready,
   input wire logic [7:0] cfg_word,
   input wire logic [7:0] cfg_check,
   output logic cfg_error,
   // Decoder result
   input wire logic tag_valid,
   input wire logic [reader_pkg::ID_W-1:0] tag_id,
   // Serial and log outputs
   output logic ser_send,
   output logic [reader_pkg::ID_W-1:0] ser_id,
   output logic nv_write,
   output logic [reader_pkg::TIME_W-1:0] nv_time,
   // Host commands
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   output logic cmd_accept,
   output logic [7:0] cmd_out,
   output logic err_reply,
   output logic [7:0] err_code,
   // Front end and user outputs
   output logic carrier_out,
   output logic rx_hdx_en,
   output logic rx_fdx_en,
   output logic rx_data,
   output logic red_led,
   output logic beep,
   output logic reg_en,
   output logic [reader_pkg::TIME_W-1:0] seconds
);
   reader_pkg::reader_state_t state, next_state;
   logic btn_db, btn_prev, press;
   logic hdx_s1, hdx_s2, fdx_s1, fdx_s2, rtc_s1, rtc_s2, rtc_s3;
   logic burst_on, next_burst_on;
   logic [reader_pkg::DIV_W-1:0] div_cnt, next_div_cnt;
   logic [reader_pkg::PHASE_W-1:0] phase_cnt, next_phase_cnt, beep_cnt, next_beep_cnt;
   logic [reader_pkg::IDLE_W-1:0] idle_cnt, next_idle_cnt;
   logic [reader_pkg::RTC_W-1:0] rtc_div, next_rtc_div;
   logic [reader_pkg::TIME_W-1:0] next_seconds;
   logic next_reg_en, next_red_led, next_beep, next_cfg_read, next_cfg_error;
   logic next_ser_send, next_nv_write, next_cmd_accept, next_err_reply;
   logic next_rx_hdx_en, next_rx_fdx_en, next_rx_data;
   logic [reader_pkg::ID_W-1:0] next_ser_id;
   logic [reader_pkg::TIME_W-1:0] next_nv_time;
   logic [7:0] next_cmd_out, next_err_code;
   logic tag_hit, known_cmd;
   logic cfg_asked, next_cfg_asked;

   button_debounce #(.DB_CYC(DB_CYC)) u_debounce (
      .clock(clock),
      .rst_n(rst_n),
      .raw(read_button),
      .level(btn_db)
   );

   assign press = btn_db && !btn_prev;
   assign tag_hit = tag_valid && state == reader_pkg::ST_READ;
   assign carrier_out = div_cnt[reader_pkg::DIV_W-1];
   assign known_cmd = cmd_code inside {reader_pkg::CMD_VERSION, reader_pkg::CMD_CFG_QUERY,
      reader_pkg::CMD_CFG_WRITE, reader_pkg::CMD_LIST, reader_pkg::CMD_MODE};

   // Sequencer, burst timing and power latch
   always_comb begin
      next_state = state;
      next_cfg_read = 1'b0;
      next_cfg_asked = cfg_asked;
      next_cfg_error = cfg_error;
      next_reg_en = reg_en;
      next_idle_cnt = idle_cnt;
      next_burst_on = burst_on;
      next_phase_cnt = phase_cnt;
      case (state)
         reader_pkg::ST_LOAD: begin
            next_reg_en = 1'b1;
            // One request per reset, a repeated request would restart the store's answer
            next_cfg_read = !cfg_asked;
            next_cfg_asked = 1'b1;
            if (cfg_ready) begin
               next_cfg_error = (cfg_check != ~cfg_word);
               next_state = reader_pkg::ST_IDLE;
            end
         end
         reader_pkg::ST_IDLE: begin
            if (press) begin
               next_state = reader_pkg::ST_READ;
               next_burst_on = 1'b1;
               next_phase_cnt = reader_pkg::PHASE_W'(ON_CYC - 1);
            end
         end
         reader_pkg::ST_READ: begin
            if (tag_hit || !btn_db) begin
               next_state = tag_hit ? reader_pkg::ST_DONE : reader_pkg::ST_IDLE;
               next_burst_on = 1'b0;
            end else if (phase_cnt == '0) begin
               next_burst_on = !burst_on;
               next_phase_cnt = burst_on ? reader_pkg::PHASE_W'(OFF_CYC - 1)
                                         : reader_pkg::PHASE_W'(ON_CYC - 1);
            end else begin
               next_phase_cnt = phase_cnt - 1'b1;
            end
         end
         reader_pkg::ST_DONE: begin
            if (!btn_db) begin
               next_state = reader_pkg::ST_IDLE;
            end
         end
         reader_pkg::ST_OFF: begin
            next_reg_en = 1'b0;
            next_burst_on = 1'b0;
         end
         default: next_state = reader_pkg::ST_LOAD;
      endcase
      // Timer is loaded from power-up so a press that never comes still powers down
      if (state != reader_pkg::ST_OFF) begin
         if (press) begin
            next_idle_cnt = reader_pkg::IDLE_W'(IDLE_CYC - 1);
         end else if (idle_cnt == '0) begin
            next_state = reader_pkg::ST_OFF;
            next_reg_en = 1'b0;
            next_burst_on = 1'b0;
         end else begin
            next_idle_cnt = idle_cnt - 1'b1;
         end
      end
   end

   // Reset follows the coming phase, so the carrier stops on the edge the off phase starts
   always_comb begin
      next_div_cnt = next_burst_on ? div_cnt + 1'b1 : '0;
   end

   // Receive gating, indicators and reporting
   always_comb begin
      next_rx_hdx_en = state == reader_pkg::ST_READ && !burst_on;
      next_rx_fdx_en = state == reader_pkg::ST_READ && burst_on;
      next_rx_data = burst_on ? fdx_s2 : hdx_s2;
      next_red_led = next_burst_on;
      next_beep = beep;
      next_beep_cnt = beep_cnt;
      if (tag_hit) begin
         next_beep = 1'b1;
         next_beep_cnt = reader_pkg::PHASE_W'(BEEP_CYC - 1);
      end else if (beep_cnt != '0) begin
         next_beep_cnt = beep_cnt - 1'b1;
      end else begin
         next_beep = 1'b0;
      end
      next_ser_send = tag_hit;
      next_nv_write = tag_hit;
      next_ser_id = tag_hit ? tag_id : ser_id;
      next_nv_time = tag_hit ? seconds : nv_time;
      next_cmd_accept = 1'b0;
      next_err_reply = 1'b0;
      next_cmd_out = cmd_out;
      next_err_code = err_code;
      // Commands arriving mid-read are dropped, the host must retry once idle
      if (cmd_valid && state == reader_pkg::ST_IDLE) begin
         if (known_cmd) begin
            next_cmd_accept = 1'b1;
            next_cmd_out = cmd_code;
         end else begin
            next_err_reply = 1'b1;
            next_err_code = reader_pkg::ERR_BAD_CMD;
         end
      end
   end

   // Time base
   always_comb begin
      next_rtc_div = rtc_div;
      next_seconds = seconds;
      if (rtc_s2 && !rtc_s3) begin
         next_rtc_div = rtc_div + 1'b1;
         if (rtc_div == reader_pkg::RTC_W'(reader_pkg::RTC_HZ - 1)) begin
            next_seconds = seconds + 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= reader_pkg::ST_LOAD;
         btn_prev <= 1'b0;
         {hdx_s1, hdx_s2, fdx_s1, fdx_s2, rtc_s1, rtc_s2, rtc_s3} <= '0;
         burst_on <= 1'b0;
         div_cnt <= '0;
         phase_cnt <= '0;
         idle_cnt <= reader_pkg::IDLE_W'(IDLE_CYC - 1);
         beep_cnt <= '0;
         rtc_div <= '0;
         seconds <= '0;
         reg_en <= 1'b0;
         red_led <= 1'b0;
         beep <= 1'b0;
         cfg_read <= 1'b0;
         cfg_asked <= 1'b0;
         cfg_error <= 1'b0;
         ser_send <= 1'b0;
         nv_write <= 1'b0;
         ser_id <= '0;
         nv_time <= '0;
         cmd_accept <= 1'b0;
         err_reply <= 1'b0;
         cmd_out <= '0;
         err_code <= '0;
         rx_hdx_en <= 1'b0;
         rx_fdx_en <= 1'b0;
         rx_data <= 1'b0;
      end else begin
         state <= next_state;
         btn_prev <= btn_db;
         hdx_s1 <= hdx_data;
         hdx_s2 <= hdx_s1;
         fdx_s1 <= fdx_data;
         fdx_s2 <= fdx_s1;
         rtc_s1 <= rtc_clk;
         rtc_s2 <= rtc_s1;
         rtc_s3 <= rtc_s2;
         burst_on <= next_burst_on;
         div_cnt <= next_div_cnt;
         phase_cnt <= next_phase_cnt;
         idle_cnt <= next_idle_cnt;
         beep_cnt <= next_beep_cnt;
         rtc_div <= next_rtc_div;
         seconds <= next_seconds;
         reg_en <= next_reg_en;
         red_led <= next_red_led;
         beep <= next_beep;
         cfg_read <= next_cfg_read;
         cfg_asked <= next_cfg_asked;
         cfg_error <= next_cfg_error;
         ser_send <= next_ser_send;
         nv_write <= next_nv_write;
         ser_id <= next_ser_id;
         nv_time <= next_nv_time;
         cmd_accept <= next_cmd_accept;
         err_reply <= next_err_reply;
         cmd_out <= next_cmd_out;
         err_code <= next_err_code;
         rx_hdx_en <= next_rx_hdx_en;
         rx_fdx_en <= next_rx_fdx_en;
         rx_data <= next_rx_data;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_tag_hit;
      tag_valid && state == reader_pkg::ST_READ;
   endsequence
   sequence s_stopped;
      !burst_on && !red_led && beep;
   endsequence

   property p_div_period;
      burst_on && div_cnt == 7'h00 ##1 burst_on[*8] |-> div_cnt == 7'h08;
   endproperty
   a_div_period: assert property (p_div_period) else $error("divider not counting");
   property p_div_reset;
      !burst_on |-> div_cnt == 7'h00 && !carrier_out;
   endproperty
   a_div_reset: assert property (p_div_reset) else $error("carrier not quiet when off");
   property p_burst_toggle;
      state == reader_pkg::ST_READ && btn_db && !tag_valid && idle_cnt != '0 && phase_cnt == '0
         |=> burst_on != $past(burst_on);
   endproperty
   a_burst_toggle: assert property (p_burst_toggle) else $error("burst phase did not flip");
   property p_rx_gate;
      (rx_hdx_en |-> $past(!burst_on)) and (rx_fdx_en |-> $past(burst_on));
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("wrong receiver enabled");
   property p_tag_stop;
      s_tag_hit |=> s_stopped;
   endproperty
   a_tag_stop: assert property (p_tag_stop) else $error("tag did not stop carrier");
   property p_need_release;
      state == reader_pkg::ST_DONE && btn_db |=> state != reader_pkg::ST_READ;
   endproperty
   a_need_release: assert property (p_need_release) else $error("read restarted without release");
   property p_power_hold;
      $fell(reg_en) |-> $past(idle_cnt) == '0;
   endproperty
   a_power_hold: assert property (p_power_hold) else $error("regulator dropped early");
   property p_timer_restart;
      press && state != reader_pkg::ST_OFF |=> idle_cnt == reader_pkg::IDLE_W'(IDLE_CYC - 1);
   endproperty
   a_timer_restart: assert property (p_timer_restart) else $error("idle timer not restarted");
   property p_timeout;
      reg_en && idle_cnt == '0 && !press |=> !reg_en ##1 !reg_en;
   endproperty
   a_timeout: assert property (p_timeout) else $error("regulator not released");
   property p_report;
      s_tag_hit |=> ser_send && nv_write && ser_id == $past(tag_id) && nv_time == $past(seconds);
   endproperty
   a_report: assert property (p_report) else $error("tag not reported");
   property p_cmd_busy;
      cmd_valid && state != reader_pkg::ST_IDLE |=> !cmd_accept && !err_reply;
   endproperty
   a_cmd_busy: assert property (p_cmd_busy) else $error("command taken while busy");
   property p_bad_cmd;
      cmd_valid && state == reader_pkg::ST_IDLE && !known_cmd
         |=> err_reply && err_code == reader_pkg::ERR_BAD_CMD;
   endproperty
   a_bad_cmd: assert property (p_bad_cmd) else $error("no error reply");
endmodule // burst_sequencer

// *** src/reader_pkg.sv ***
package reader_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int DIV_RATIO = 128;
   localparam int DIV_W = 7;
   localparam int BURST_ON_MS = 80;
   localparam int BURST_OFF_MS = 30;
   localparam int IDLE_S = 30;
   localparam int BEEP_MS = 50;
   localparam int DEBOUNCE_MS = 10;
   localparam int RTC_HZ = 32768;
   localparam int BURST_ON_CYC = BURST_ON_MS * (CLK_HZ / 1000);
   localparam int BURST_OFF_CYC = BURST_OFF_MS * (CLK_HZ / 1000);
   localparam int IDLE_CYC = IDLE_S * CLK_HZ;
   localparam int BEEP_CYC = BEEP_MS * (CLK_HZ / 1000);
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int PHASE_W = 21;
   localparam int IDLE_W = 30;
   localparam int RTC_W = 15;
   localparam int ID_W = 64;
   localparam int TIME_W = 32;
   localparam logic [7:0] CMD_VERSION = 8'h01;
   localparam logic [7:0] CMD_CFG_QUERY = 8'h02;
   localparam logic [7:0] CMD_CFG_WRITE = 8'h03;
   localparam logic [7:0] CMD_LIST = 8'h04;
   localparam logic [7:0] CMD_MODE = 8'h05;
   localparam logic [7:0] ERR_BAD_CMD = 8'hE1;
   typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_READ, ST_DONE, ST_OFF} reader_state_t;
endpackage

// *** src/button_debounce.sv ***
`timescale 1ns/10ps
module button_debounce #(
   parameter int DB_CYC = reader_pkg::DEBOUNCE_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Raw pin and clean level
   input wire logic raw,
   output logic level
);
   logic s1, s2;
   logic [reader_pkg::PHASE_W-1:0] cnt, next_cnt;
   logic next_level;

   // Input must hold a new level for the whole window before it is believed
   always_comb begin
      next_level = level;
      next_cnt = cnt;
      if (s2 == level) begin
         next_cnt = '0;
      end else if (cnt == reader_pkg::PHASE_W'(DB_CYC - 1)) begin
         next_level = s2;
         next_cnt = '0;
      end else begin
         next_cnt = cnt + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         cnt <= '0;
         level <= 1'b0;
      end else begin
         s1 <= raw;
         s2 <= s1;
         cnt <= next_cnt;
         level <= next_level;
      end
   end
endmodule // button_debounce

// *** verif/fe_partner.sv ***
`timescale 1ns/10ps
module fe_partner (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Scenario control
   input wire logic bad_cfg,
   // Configuration store
   input wire logic cfg_read,
   output logic cfg_ready,
   output logic [7:0] cfg_word,
   output logic [7:0] cfg_check,
   // Demodulators and time base
   output logic hdx_data,
   output logic fdx_data,
   output logic rtc_clk
);
   logic [2:0] dly = 3'h0;
   logic [7:0] junk = 8'h00;
   // Distinct fixed levels show which demodulator is routed
   assign hdx_data = 1'b1;
   assign fdx_data = 1'b0;
   initial rtc_clk = 1'b0;
   // Time base at half the system rate keeps the run short
   always @(negedge clock) begin
      rtc_clk <= ~rtc_clk;
      junk <= junk + 8'h3B;
   end
   // Store answers a few cycles after the load request
   always @(negedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dly <= 3'h0;
      end else begin
         dly <= cfg_read ? 3'h3 : (dly != 3'h0 ? dly - 3'h1 : 3'h0);
      end
   end
   // Bus carries junk outside the answer cycle
   assign cfg_ready = (dly == 3'h1);
   assign cfg_word = cfg_ready ? 8'hA5 : junk;
   assign cfg_check = cfg_ready ? (bad_cfg ? 8'h5B : 8'h5A) : junk;
endmodule // fe_partner

// *** verif/tb_rfid_burst_power_sequencer.sv ***
`timescale 1ns/10ps
module tb_rfid_burst_power_sequencer;
   localparam int ON = 200;
   localparam int OFF = 80;
   localparam int IDLE = 5000;
   localparam int BEEP = 20;
   logic clock, rst_n, read_button, hdx_data, fdx_data, rtc_clk, bad_cfg;
   logic cfg_read, cfg_ready, cfg_error, tag_valid, ser_send, nv_write;
   logic cmd_valid, cmd_accept, err_reply, carrier_out, rx_hdx_en, rx_fdx_en;
   logic rx_data, red_led, beep, reg_en;
   logic [7:0] cfg_word, cfg_check, cmd_code, cmd_out, err_code, rc;
   logic [63:0] tag_id, ser_id, id;
   logic [31:0] nv_time, seconds;
   logic pc, bad;
   int num_errors = 0;
   int n_tests = 0;
   int seed = 50;
   int t, r, f, r2, s, w, b;

   burst_sequencer #(.ON_CYC(ON), .OFF_CYC(OFF), .IDLE_CYC(IDLE), .BEEP_CYC(BEEP), .DB_CYC(4)) dut_u (
      .clock(clock), .rst_n(rst_n), .read_button(read_button), .hdx_data(hdx_data),
      .fdx_data(fdx_data), .rtc_clk(rtc_clk), .cfg_read(cfg_read), .cfg_ready(cfg_ready),
      .cfg_word(cfg_word), .cfg_check(cfg_check), .cfg_error(cfg_error), .tag_valid(tag_valid),
      .tag_id(tag_id), .ser_send(ser_send), .ser_id(ser_id), .nv_write(nv_write), .nv_time(nv_time),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_accept(cmd_accept), .cmd_out(cmd_out),
      .err_reply(err_reply), .err_code(err_code), .carrier_out(carrier_out), .rx_hdx_en(rx_hdx_en),
      .rx_fdx_en(rx_fdx_en), .rx_data(rx_data), .red_led(red_led), .beep(beep), .reg_en(reg_en),
      .seconds(seconds));

   fe_partner fe_u (.clock(clock), .rst_n(rst_n), .bad_cfg(bad_cfg), .cfg_read(cfg_read),
      .cfg_ready(cfg_ready), .cfg_word(cfg_word), .cfg_check(cfg_check), .hdx_data(hdx_data),
      .fdx_data(fdx_data), .rtc_clk(rtc_clk));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Expected reply byte: the code itself for a known command, else the error code
   function automatic logic [7:0] exp_code(input logic [7:0] c);
      return (c inside {[reader_pkg::CMD_VERSION:reader_pkg::CMD_MODE]}) ? c : reader_pkg::ERR_BAD_CMD;
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic do_reset(input logic bc);
      int n;
      n = 0;
      rst_n = 1'b0;
      bad_cfg = bc;
      cyc(10);
      rst_n = 1'b1;
      repeat (20) begin
         cyc(1);
         n += int'(cfg_read === 1'b1);
      end
      check(n, 1);
   endtask

   // Bounded wait for the red indicator to reach a level
   task automatic wait_red(input logic v);
      int k;
      k = 0;
      while (red_led !== v && k < 2000) begin
         cyc(1);
         k++;
      end
   endtask

   task automatic send_cmd(input logic [7:0] c, input logic ok, input logic live);
      logic acc, err;
      acc = 1'b0;
      err = 1'b0;
      cmd_valid = 1'b1;
      cmd_code = c;
      cyc(1);
      cmd_valid = 1'b0;
      cmd_code = ~c;
      repeat (3) begin
         acc = acc | cmd_accept;
         err = err | err_reply;
         cyc(1);
      end
      check(acc, live & ok);
      check(err, live & ~ok);
      if (live) check(ok ? cmd_out : err_code, exp_code(c));
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge clock);
      num_errors++;
      results();
   end

   initial begin
      read_button = 1'b0;
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      tag_valid = 1'b0;
      tag_id = 64'h0;
      do_reset(1'b1);
      check(cfg_error, 1'b1);
      do_reset(1'b0);
      check(cfg_error, 1'b0);
      check(reg_en, 1'b1);
      $display("config test done");
      for (int c = 1; c <= 5; c++) send_cmd(8'(c), 1'b1, 1'b1);
      send_cmd(8'h00, 1'b0, 1'b1);
      send_cmd(8'hFF, 1'b0, 1'b1);
      repeat (3) begin
         rc = 8'h06 + 8'($random(seed) & 32'h7F);
         send_cmd(rc, 1'b0, 1'b1);
      end
      $display("command test done");
      read_button = 1'b1;
      cyc(2);
      read_button = 1'b0;
      cyc(15);
      check(red_led, 1'b0);
      $display("debounce test done");
      read_button = 1'b1;
      wait_red(1'b1);
      check(red_led, 1'b1);
      t = 0; r = 0; f = 0; r2 = 0; bad = 1'b0; pc = 1'b0;
      while (red_led === 1'b1 && t < 1000) begin
         if (carrier_out === 1'b1 && pc === 1'b0) begin
            if (r == 0) r = t;
            else if (r2 == 0) r2 = t;
         end
         if (carrier_out === 1'b0 && pc === 1'b1 && f == 0) f = t;
         if (t > 4) bad = bad | (rx_fdx_en !== 1'b1) | (rx_hdx_en !== 1'b0) | (rx_data !== 1'b0);
         pc = carrier_out;
         t++;
         cyc(1);
      end
      check(t, ON);
      check(f - r, 64);
      check(r2 - f, 64);
      check(bad, 1'b0);
      t = 0; bad = 1'b0;
      while (red_led === 1'b0 && t < 1000) begin
         if (t > 4) bad = bad | (rx_hdx_en !== 1'b1) | (rx_fdx_en !== 1'b0) | (rx_data !== 1'b1);
         bad = bad | (carrier_out !== 1'b0);
         t++;
         cyc(1);
      end
      check(t, OFF);
      check(bad, 1'b0);
      $display("burst test done");
      send_cmd(reader_pkg::CMD_VERSION, 1'b1, 1'b0);
      id = {$random(seed), $random(seed)};
      tag_valid = 1'b1;
      tag_id = id;
      cyc(1);
      tag_valid = 1'b0;
      tag_id = ~id;
      s = 0; w = 0; b = 0; bad = 1'b0;
      for (int k = 0; k < BEEP + 10; k++) begin
         s += int'(ser_send === 1'b1);
         w += int'(nv_write === 1'b1);
         b += int'(beep === 1'b1);
         if (k > 1) bad = bad | (carrier_out !== 1'b0) | (red_led !== 1'b0);
         cyc(1);
      end
      check(s, 1);
      check(w, 1);
      check(ser_id, id);
      check(nv_time, 32'h0);
      check(b, BEEP);
      check(bad, 1'b0);
      cyc(300);
      check(red_led, 1'b0);
      read_button = 1'b0;
      cyc(10);
      read_button = 1'b1;
      wait_red(1'b1);
      check(red_led, 1'b1);
      read_button = 1'b0;
      $display("tag test done");
      // Timer would run out during this wait unless the press restarts it
      cyc(3000);
      read_button = 1'b1;
      cyc(12);
      read_button = 1'b0;
      cyc(IDLE - 150);
      check(reg_en, 1'b1);
      cyc(300);
      check(reg_en, 1'b0);
      $display("power test done");
      do_reset(1'b0);
      cyc(65400 - 20);
      check(seconds, 32'h0);
      cyc(300);
      check(seconds, 32'h1);
      $display("time base test done");
      results();
   end
endmodule // tb_rfid_burst_power_sequencer
